// ---- design/flash_seq_regs.svh ----
// Register offsets, field positions, key values and timing counts
`ifndef FLASH_SEQ_REGS_SVH
`define FLASH_SEQ_REGS_SVH
`define CTL_OFS 5'h00
`define KEY_OFS 5'h04
`define PAGE_OFS 5'h08
`define OFFS_OFS 5'h0C
`define TWL_OFS 5'h10
`define TWH_OFS 5'h14
`define TRIG_BIT 15
`define PERMIT_BIT 14
`define ERR_BIT 13
`define ERASE_BIT 6
`define OP_MSB 3
`define OP_LSB 0
`define CTL_RESET 16'h0000
`define OP_ERASE 4'h2
`define OP_ROW 4'h1
`define KEY_FIRST 8'h55
`define KEY_SECOND 8'hAA
`define ROW_WORDS 7'h40
`define BLOCK_MASK 24'hFFFC00
`define ROW_MASK 24'hFFFF80
`define CLK_NS 5
`define ERASE_TIME_NS 20000
`define PROG_TIME_NS 10000
`define ERASE_CYC ((`ERASE_TIME_NS + `CLK_NS - 1) / `CLK_NS)
`define PROG_CYC ((`PROG_TIME_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// ---- design/flash_seq_pkg.sv ----
// Types for the flash erase and row program sequencer
package flash_seq_pkg;
    typedef enum logic [1:0] {key_idle, key_first, key_armed} key_state_type;
    typedef enum logic [1:0] {seq_idle, seq_erase, seq_program} seq_state_type;
    typedef struct packed {
        logic trig;
        logic permit;
        logic err;
        logic erase_sel;
        logic [3:0] op;
        key_state_type key;
        seq_state_type seq;
        logic [11:0] cnt;
        logic [6:0] idx;
        logic [7:0] page;
        logic [15:0] offs;
        logic [23:0] blk;
        logic [15:0] rdata;
        logic [23:0] f_addr;
        logic [23:0] f_wdata;
        logic f_we;
        logic f_erase;
    } state_type;
endpackage : flash_seq_pkg

// ---- design/flash_row_erase_program_ctrl.sv ----
// Flash block erase and row program sequencer with unlock key
`timescale 1ns/1ps
`include "flash_seq_regs.svh"

module flash_row_erase_program_ctrl (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic cpu_stall,
    output logic flash_erase,
    output logic flash_we,
    output logic [23:0] flash_addr,
    output logic [23:0] flash_wdata
);

    localparam logic [11:0] ERASE_LAST = 12'(`ERASE_CYC - 1);
    localparam logic [11:0] PROG_LAST = 12'(`PROG_CYC - 1);

    flash_seq_pkg::state_type s;
    flash_seq_pkg::state_type next_s;
    logic [23:0] latch [0:63];
    logic busy;
    logic wr_ctl;
    logic wr_key;
    logic trig_wr;
    logic op_ok;
    logic start;
    logic [3:0] new_op;

    ////////////////////////////////////////////////////////////////
    // Decode

    always_comb begin
        busy = s.seq != flash_seq_pkg::seq_idle;
        wr_ctl = reg_wr && reg_addr == `CTL_OFS;
        wr_key = reg_wr && reg_addr == `KEY_OFS;
        new_op = reg_wdata[`OP_MSB:`OP_LSB];
        trig_wr = wr_ctl && reg_wdata[`TRIG_BIT] && !busy;
        // Erase flag must match the operation code
        op_ok = (reg_wdata[`ERASE_BIT] && new_op == `OP_ERASE) ||
            (!reg_wdata[`ERASE_BIT] && new_op == `OP_ROW);
        start = trig_wr && s.key == flash_seq_pkg::key_armed
            && reg_wdata[`PERMIT_BIT] && op_ok;
    end

    ////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_s = s;
        next_s.f_we = 1'b0;
        next_s.f_erase = 1'b0;
        next_s.rdata = 16'h0000;

        // Unlock key tracking
        if (reg_wr && !busy) begin
            if (wr_key && reg_wdata[7:0] == `KEY_FIRST) begin
                next_s.key = flash_seq_pkg::key_first;
            end else if (wr_key && reg_wdata[7:0] == `KEY_SECOND
                && s.key == flash_seq_pkg::key_first) begin
                next_s.key = flash_seq_pkg::key_armed;
            end else begin
                // Any other write spends or drops the key
                next_s.key = flash_seq_pkg::key_idle;
            end
        end

        // Register writes; CPU is stalled while busy
        if (reg_wr && !busy) begin
            unique case (reg_addr)
                `CTL_OFS: begin
                    next_s.permit = reg_wdata[`PERMIT_BIT];
                    next_s.erase_sel = reg_wdata[`ERASE_BIT];
                    next_s.op = new_op;
                    next_s.err = reg_wdata[`ERR_BIT];
                end
                `PAGE_OFS: begin
                    next_s.page = reg_wdata[7:0];
                end
                `OFFS_OFS: begin
                    next_s.offs = reg_wdata;
                end
                `TWL_OFS: begin
                    next_s.blk = {s.page, s.offs};
                end
                `TWH_OFS: begin
                    next_s.offs = s.offs + 16'h0002;
                end
                default: begin
                end
            endcase
        end

        // Error set wins over a software clear
        if (trig_wr && !start) begin
            next_s.err = 1'b1;
        end

        // Sequencer
        unique case (s.seq)
            flash_seq_pkg::seq_idle: begin
                if (start) begin
                    next_s.trig = 1'b1;
                    next_s.cnt = 12'h000;
                    next_s.idx = 7'h00;
                    if (reg_wdata[`ERASE_BIT]) begin
                        next_s.seq = flash_seq_pkg::seq_erase;
                        next_s.f_erase = 1'b1;
                        next_s.f_addr = s.blk & `BLOCK_MASK;
                    end else begin
                        next_s.seq = flash_seq_pkg::seq_program;
                    end
                end
            end
            flash_seq_pkg::seq_erase: begin
                next_s.cnt = s.cnt + 12'h001;
                if (s.cnt == ERASE_LAST) begin
                    next_s.seq = flash_seq_pkg::seq_idle;
                    next_s.trig = 1'b0;
                end
            end
            flash_seq_pkg::seq_program: begin
                next_s.cnt = s.cnt + 12'h001;
                if (s.idx < `ROW_WORDS) begin
                    // Stream one latched word per cycle
                    next_s.f_we = 1'b1;
                    next_s.f_addr = (s.blk & `ROW_MASK) + {16'h0000, s.idx, 1'b0};
                    next_s.f_wdata = latch[s.idx[5:0]];
                    next_s.idx = s.idx + 7'h01;
                end
                if (s.cnt == PROG_LAST) begin
                    next_s.seq = flash_seq_pkg::seq_idle;
                    next_s.trig = 1'b0;
                end
            end
            default: begin
                next_s.seq = flash_seq_pkg::seq_idle;
                next_s.trig = 1'b0;
            end
        endcase

        // Read data in the following cycle
        if (reg_rd) begin
            unique case (reg_addr)
                `CTL_OFS: begin
                    next_s.rdata = {s.trig, s.permit, s.err, 6'h00,
                        s.erase_sel, 2'h0, s.op};
                end
                `PAGE_OFS: begin
                    next_s.rdata = {8'h00, s.page};
                end
                `OFFS_OFS: begin
                    next_s.rdata = s.offs;
                end
                default: begin
                    next_s.rdata = 16'h0000;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s <= '0;
            s.trig <= 1'(`CTL_RESET >> `TRIG_BIT);
            s.key <= flash_seq_pkg::key_idle;
            s.seq <= flash_seq_pkg::seq_idle;
        end else begin
            s <= next_s;
        end
    end

    // Write latches, filled by table writes
    always_ff @(posedge clk_sys) begin
        if (reg_wr && !busy && reg_addr == `TWL_OFS) begin
            latch[s.offs[6:1]][15:0] <= reg_wdata;
        end
        if (reg_wr && !busy && reg_addr == `TWH_OFS) begin
            latch[s.offs[6:1]][23:16] <= reg_wdata[7:0];
        end
    end

    assign reg_rdata = s.rdata;
    assign cpu_stall = busy;
    assign flash_erase = s.f_erase;
    assign flash_we = s.f_we;
    assign flash_addr = s.f_addr;
    assign flash_wdata = s.f_wdata;

    ////////////////////////////////////////////////////////////////
    // Checks

    logic [6:0] we_run;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            we_run <= 7'h00;
        end else if (s.f_we) begin
            we_run <= we_run + 7'h01;
        end else begin
            we_run <= 7'h00;
        end
    end

    sequence armed_trigger;
        s.key == flash_seq_pkg::key_armed && trig_wr;
    endsequence

    sequence run_end;
        busy ##1 !busy;
    endsequence

    key_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(busy) |-> $past(s.key) == flash_seq_pkg::key_armed)
        else $error("cycle started without unlock");
    permit_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
        (trig_wr && !reg_wdata[`PERMIT_BIT]) |=> !busy && s.err)
        else $error("cycle ran with permit clear");
    bad_trigger_a: assert property (@(posedge clk_sys) disable iff (rst)
        (trig_wr && s.key != flash_seq_pkg::key_armed) |=> s.err && !s.trig)
        else $error("improper trigger not flagged");
    erase_start_a: assert property (@(posedge clk_sys) disable iff (rst)
        (armed_trigger ##0 start ##0 reg_wdata[`ERASE_BIT])
        |=> flash_erase && cpu_stall && s.trig && flash_addr[9:0] == 10'h000)
        else $error("erase start wrong");
    trig_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
        run_end |-> !s.trig && !cpu_stall
            && ($past(s.cnt) == ERASE_LAST || $past(s.cnt) == PROG_LAST))
        else $error("trigger not cleared at end");
    stall_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
        s.trig |-> cpu_stall)
        else $error("trigger set without stall");
    row_length_a: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(s.f_we) |-> $past(we_run) == 7'h3F)
        else $error("row burst not 64 words");
    key_discard_a: assert property (@(posedge clk_sys) disable iff (rst)
        (reg_wr && !busy && !wr_key) |=> s.key == flash_seq_pkg::key_idle)
        else $error("partial key kept");

endmodule : flash_row_erase_program_ctrl

// ---- tb/tb_top.sv ----
// Self-checking bench for the flash erase and row program sequencer
`timescale 1ns/1ps
`include "flash_seq_regs.svh"

module tb_top;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [4:0] reg_addr = 5'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic cpu_stall;
    logic flash_erase;
    logic flash_we;
    logic [23:0] flash_addr;
    logic [23:0] flash_wdata;
    int num_errors = 0;
    int num_checks = 0;
    int erase_cnt = 0;
    int we_cnt = 0;
    logic [23:0] erase_at = 24'h000000;
    logic [15:0] bad_ctl [5] = '{16'hC042, 16'hC042, 16'h8042, 16'hC002, 16'hC001};
    int bad_mode [5] = '{0, 1, 2, 2, 3};

    flash_row_erase_program_ctrl i_flash_row_erase_program_ctrl (
        .clk_sys(clk_sys),
        .rst(rst),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .cpu_stall(cpu_stall),
        .flash_erase(flash_erase),
        .flash_we(flash_we),
        .flash_addr(flash_addr),
        .flash_wdata(flash_wdata)
    );

    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [23:0] word_of(input int i);
        return {8'hC0 + 8'(i), 16'h1000 + 16'(i)};
    endfunction : word_of

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic print_verdict;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk({8'h00, reg_rdata}, {8'h00, exp});
    endtask : rd_chk

    // Counts stall cycles from the trigger write edge on
    task automatic wait_stall(input int exp_cyc);
        int n = 0;
        bit done = 1'b0;
        for (int i = 0; i < 6000 && !done; i++) begin
            #1;
            if (cpu_stall === 1'b1) n++;
            else done = 1'b1;
            if (!done) @(posedge clk_sys);
        end
        if (!done) begin
            num_errors++;
            print_verdict();
        end else begin
            chk(24'(n), 24'(exp_cyc));
        end
    endtask : wait_stall

    // Flash side monitor
    always @(posedge clk_sys) begin
        if (flash_erase === 1'b1) begin
            erase_cnt <= erase_cnt + 1;
            erase_at <= flash_addr;
        end
        if (flash_we === 1'b1) begin
            chk(flash_addr, 24'h016000 + 24'(2 * we_cnt));
            chk(flash_wdata, word_of(we_cnt));
            we_cnt <= we_cnt + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        rd_chk(`CTL_OFS, `CTL_RESET);
        rd_chk(`KEY_OFS, 16'h0000);
        rd_chk(5'h1C, 16'h0000);
        $display("test reset done");
        // Block erase from an unaligned table address
        wr(`CTL_OFS, 16'h4042);
        wr(`PAGE_OFS, 16'h0001);
        wr(`OFFS_OFS, 16'h6100);
        wr(`TWL_OFS, 16'h0000);
        wr(`KEY_OFS, 16'h0055);
        wr(`KEY_OFS, 16'h00AA);
        wr(`CTL_OFS, 16'hC042);
        wait_stall(`ERASE_CYC);
        chk(24'(erase_cnt), 24'h000001);
        chk(erase_at, 24'h016000);
        rd_chk(`CTL_OFS, 16'h4042);
        $display("test erase done");
        // Row program of 64 latched words
        wr(`CTL_OFS, 16'h4001);
        wr(`OFFS_OFS, 16'h6000);
        for (int i = 0; i < 64; i++) begin
            logic [23:0] w;
            w = word_of(i);
            wr(`TWL_OFS, w[15:0]);
            wr(`TWH_OFS, {8'h00, w[23:16]});
        end
        wr(`KEY_OFS, 16'h0055);
        wr(`KEY_OFS, 16'h00AA);
        wr(`CTL_OFS, 16'hC001);
        wait_stall(`PROG_CYC);
        chk(24'(we_cnt), 24'h000040);
        rd_chk(`CTL_OFS, 16'h4001);
        rd_chk(`PAGE_OFS, 16'h0001);
        rd_chk(`OFFS_OFS, 16'h6080);
        $display("test row program done");
        // Improper triggers: no key, broken key, permit clear, erase flag and op code mismatch
        for (int k = 0; k < 5; k++) begin
            wr(`CTL_OFS, 16'h0000);
            if (bad_mode[k] != 0) wr(`KEY_OFS, 16'h0055);
            if (bad_mode[k] == 1) wr(`PAGE_OFS, 16'h0001);
            if (bad_mode[k] == 3) wr(5'h1C, 16'h0000);
            if (bad_mode[k] != 0) wr(`KEY_OFS, 16'h00AA);
            wr(`CTL_OFS, bad_ctl[k]);
            repeat (4) @(posedge clk_sys);
            #1;
            chk({23'h0, cpu_stall}, 24'h000000);
            rd_chk(`CTL_OFS, (bad_ctl[k] & 16'h404F) | 16'h2000);
        end
        chk(24'(erase_cnt), 24'h000001);
        chk(24'(we_cnt), 24'h000040);
        wr(`CTL_OFS, 16'h0000);
        rd_chk(`CTL_OFS, 16'h0000);
        $display("test refusals done");
        print_verdict();
    end
endmodule : tb_top
